// [hw/sgdc_pkg.sv]
// shared constants and types of the scatter-gather dma control block
package sgdc_pkg;

  // ----------------------------------------------------------------
  // engine population
  // ----------------------------------------------------------------
  localparam int NUM_S2C = 2;
  localparam int NUM_C2S = 2;
  localparam int NUM_ENG = NUM_S2C + NUM_C2S;
  localparam int ADDR_W  = 16;
  localparam int DATA_W  = 32;
  localparam int XFER_W  = 16;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] CH_S2C0_BASE  = 16'h0000;
  localparam logic [15:0] CH_S2C1_BASE  = 16'h0100;
  localparam logic [15:0] CH_C2S0_BASE  = 16'h2000;
  localparam logic [15:0] CH_C2S1_BASE  = 16'h2100;
  localparam logic [15:0] COMMON_BASE   = 16'h4000;
  localparam logic [7:0]  REG_ENG_CTL   = 8'h04;
  localparam logic [7:0]  REG_NEXT_PTR  = 8'h08;
  localparam logic [7:0]  REG_SW_PTR    = 8'h0C;
  localparam logic [7:0]  REG_BYTE_CNT  = 8'h1D;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_IEN   = 0;
  localparam int BIT_IACT  = 1;
  localparam int BIT_DONE  = 2;
  localparam int BIT_ALIGN = 3;
  localparam int BIT_FERR  = 4;
  localparam int BIT_ABORT = 5;
  localparam int BIT_EN    = 8;
  localparam int BIT_RUN   = 10;
  localparam int BIT_WAIT  = 11;
  localparam int BIT_RREQ  = 14;
  localparam int BIT_RST   = 15;
  localparam int BIT_GIE   = 0;
  localparam int BIT_GACT  = 1;
  localparam int BIT_GPEND = 2;
  localparam int S2C_LSB   = 16;
  localparam int C2S_LSB   = 24;
  localparam int PTR_LSB   = 5;
  localparam int CNT_LSB   = 2;
  localparam int PTR_W     = DATA_W - PTR_LSB;

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RST = 27'h0000000;
  localparam logic             BIT_RSTV = 1'b0;
  localparam longint SAMPLE_NS = 1000000000;
  localparam longint CLK_NS    = 10;
  localparam int unsigned TICK_CYC = int'(SAMPLE_NS / CLK_NS);

  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b00,
    ENG_FETCH = 2'b01,
    ENG_WAIT  = 2'b10
  } sgdc_eng_state_t;

endpackage : sgdc_pkg

// [hw/sgdc_tick.sv]
// one-second sample strobe divider
module sgdc_tick #(
  parameter int unsigned CYCLES = sgdc_pkg::TICK_CYC
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_b,
  output logic      o_tick
);
  import sgdc_pkg::*;

  localparam int CW = $clog2(CYCLES) + 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } sgdc_tick_st_t;

  sgdc_tick_st_t q;
  sgdc_tick_st_t d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == CW'(CYCLES - 1))
    begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = CW'(q.cnt + 1'b1);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign o_tick = q.tick;
endmodule : sgdc_tick

// [hw/sgdc_rate.sv]
// per-engine completed byte counter sampled once a second
module sgdc_rate (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_tick,
  input  wire logic                          i_clr,
  input  wire logic [sgdc_pkg::XFER_W-1:0]   i_bytes,
  output logic [sgdc_pkg::DATA_W-3:0]        o_count,
  output logic [1:0]                         o_samples
);
  import sgdc_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-3:0] cnt;
    logic [1:0]        smp;
  } sgdc_rate_st_t;

  sgdc_rate_st_t q;
  sgdc_rate_st_t d;

  always_comb
  begin
    d = q;
    if (i_clr)
    begin
      d = '0;
    end
    else if (i_tick)
    begin
      d.cnt = q.acc[DATA_W-1:CNT_LSB];
      d.acc = DATA_W'(i_bytes);
      d.smp = 2'(q.smp + 2'h1);
    end
    else
    begin
      d.acc = DATA_W'(q.acc + DATA_W'(i_bytes));
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      q <= '0;
    else
      q <= d;
  end

  assign o_count   = q.cnt;
  assign o_samples = q.smp;

  property p_sample_step;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_tick && !i_clr) |=> (q.smp == 2'($past(q.smp) + 2'h1));
  endproperty
  a_sample_step: assert property (p_sample_step)
    else $error("sample counter did not step on tick");
endmodule : sgdc_rate

// [hw/sgdc_top.sv]
// scatter-gather dma engine control, status and common interrupt registers
// How it works
// - S2C channels at 0x0/0x100, C2S channels at 0x2000/0x2100.
// - each channel has same registers at channel base plus register offset.
// - common interrupt registers decode at 0x4000.
// - any interrupt event sets active bit 1, w1c; bit 0 enables interrupts.
// - descriptor with interrupt-on-completion done sets bit 2 and active.
// - misaligned descriptor address aborts, sets bit 3, raises interrupt.
// - failed descriptor fetch sets bit 4 and raises interrupt.
// - software abort of a running operation sets bit 5.
// - enabled engine compares next and software pointers to start.
// - bit 10 reads high while an operation is in progress.
// - bit 11 reads high while waiting for more descriptors.
// - bit 14 requests user logic reset prep; cleared by user acknowledge.
// - bit 15 resets the engine and drives reset to user logic.
// - next pointer writable only while engine is disabled.
// - low five pointer bits read zero, forcing 32-byte alignment.
// - byte count bits 31:2 show last second's bytes, 4-byte units.
// - two-bit sample count increments at each one-second capture.
// - common bit 0 globally enables interrupts of all engines.
// - common bit 1 gated interrupt state, bit 2 ungated state.
// - common bits 23:16 S2C, 31:24 C2S engine interrupt status.
module sgdc_top #(
  parameter int unsigned TICK_CYCLES = sgdc_pkg::TICK_CYC
) (
  input  wire logic                                        i_ref_clk,
  input  wire logic                                        i_rst_b,
  input  wire logic                                        i_reg_wr,
  input  wire logic                                        i_reg_rd,
  input  wire logic [sgdc_pkg::ADDR_W-1:0]                 i_reg_addr,
  input  wire logic [sgdc_pkg::DATA_W-1:0]                 i_reg_wdata,
  output logic      [sgdc_pkg::DATA_W-1:0]                 o_reg_rdata,
  output logic                                             o_reg_rvalid,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_fetch_req,
  output logic      [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::PTR_W-1:0] o_fetch_ptr,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_desc_done,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_desc_ioc,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::DATA_W-1:0] i_desc_next,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_fetch_err,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::XFER_W-1:0] i_xfer_bytes,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_user_rst_req,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_user_rst_ack,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_user_rst,
  output logic                                             o_irq
);
  import sgdc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sgdc_eng_state_t  st;
    logic             ien;
    logic             iact;
    logic             done;
    logic             align;
    logic             ferr;
    logic             abrt;
    logic             en;
    logic             rreq;
    logic             rst;
    logic             req;
    logic [PTR_W-1:0] nxt;
    logic [PTR_W-1:0] sw;
  } sgdc_eng_t;

  typedef struct packed {
    sgdc_eng_t [NUM_ENG-1:0] eng;
    logic                    gie;
    logic                    irq;
    logic [DATA_W-1:0]       rdata;
    logic                    rvalid;
  } sgdc_top_st_t;

  sgdc_top_st_t q;
  sgdc_top_st_t d;

  logic                              tick;
  logic [NUM_ENG-1:0][DATA_W-3:0]    byte_cnt;
  logic [NUM_ENG-1:0][1:0]           smp_cnt;
  logic [NUM_ENG-1:0]                eng_irq;
  logic [NUM_ENG-1:0]                wr_ctl;
  logic [NUM_ENG-1:0]                wr_nxt;
  logic [NUM_ENG-1:0]                wr_sw;
  logic [NUM_ENG-1:0]                ev_done;
  logic [NUM_ENG-1:0]                ev_mis;
  logic [NUM_ENG-1:0]                ev_ferr;
  logic [2:0]                        sel;
  logic [7:0]                        off;
  logic                              rst_keep;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // returns {hit, engine index}
  function automatic logic [2:0] eng_sel(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a[15:8] == CH_S2C0_BASE[15:8])
      r = {1'b1, 2'h0};
    else if (a[15:8] == CH_S2C1_BASE[15:8])
      r = {1'b1, 2'h1};
    else if (a[15:8] == CH_C2S0_BASE[15:8])
      r = {1'b1, 2'h2};
    else if (a[15:8] == CH_C2S1_BASE[15:8])
      r = {1'b1, 2'h3};
    return r;
  endfunction : eng_sel

  function automatic logic [DATA_W-1:0] ctl_word(input sgdc_eng_t e);
    logic [DATA_W-1:0] w;
    w = '0;
    w[BIT_IEN]   = e.ien;
    w[BIT_IACT]  = e.iact;
    w[BIT_DONE]  = e.done;
    w[BIT_ALIGN] = e.align;
    w[BIT_FERR]  = e.ferr;
    w[BIT_ABORT] = e.abrt;
    w[BIT_EN]    = e.en;
    w[BIT_RUN]   = (e.st == ENG_FETCH);
    w[BIT_WAIT]  = (e.st == ENG_WAIT);
    w[BIT_RREQ]  = e.rreq;
    w[BIT_RST]   = e.rst;
    return w;
  endfunction : ctl_word

  // ----------------------------------------------------------------
  // sample strobe and byte counters
  // ----------------------------------------------------------------
  sgdc_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (i_rst_b),
    .o_tick    (tick)
  );

  for (genvar g = 0; g < NUM_ENG; g++)
  begin : g_rate
    sgdc_rate u_rate (
      .i_ref_clk (i_ref_clk),
      .i_rst_b   (i_rst_b),
      .i_tick    (tick),
      .i_clr     (q.eng[g].rst),
      .i_bytes   (i_xfer_bytes[g]),
      .o_count   (byte_cnt[g]),
      .o_samples (smp_cnt[g])
    );
  end

  // ----------------------------------------------------------------
  // engine and register logic
  // ----------------------------------------------------------------
  always_comb
  begin
    d        = q;
    sel      = eng_sel(i_reg_addr);
    off      = i_reg_addr[7:0];
    rst_keep = 1'b0;
    for (int e = 0; e < NUM_ENG; e++)
    begin
      wr_ctl[e]  = i_reg_wr && sel[2] && (sel[1:0] == 2'(e)) && (off == REG_ENG_CTL);
      wr_nxt[e]  = i_reg_wr && sel[2] && (sel[1:0] == 2'(e)) && (off == REG_NEXT_PTR);
      wr_sw[e]   = i_reg_wr && sel[2] && (sel[1:0] == 2'(e)) && (off == REG_SW_PTR);
      ev_done[e] = (q.eng[e].st == ENG_FETCH) && i_desc_done[e];
      ev_mis[e]  = ev_done[e] && (i_desc_next[e][PTR_LSB-1:0] != 5'h00);
      ev_ferr[e] = (q.eng[e].st == ENG_FETCH) && i_fetch_err[e];
      eng_irq[e] = q.eng[e].ien && q.eng[e].iact;
      d.eng[e].req = 1'b0;
      if (i_user_rst_ack[e])
        d.eng[e].rreq = 1'b0;
      if (wr_ctl[e])
      begin
        // enable bit and w1c of active
        d.eng[e].ien = i_reg_wdata[BIT_IEN];
        d.eng[e].en  = i_reg_wdata[BIT_EN];
        d.eng[e].rst = i_reg_wdata[BIT_RST];
        if (i_reg_wdata[BIT_RREQ])
          d.eng[e].rreq = 1'b1;
        if (i_reg_wdata[BIT_IACT])
          d.eng[e].iact = 1'b0;
        if (i_reg_wdata[BIT_DONE])
          d.eng[e].done = 1'b0;
        if (i_reg_wdata[BIT_ALIGN])
          d.eng[e].align = 1'b0;
        if (i_reg_wdata[BIT_FERR])
          d.eng[e].ferr = 1'b0;
        if (i_reg_wdata[BIT_ABORT])
          d.eng[e].abrt = 1'b0;
      end
      if (wr_nxt[e] && !q.eng[e].en)
        d.eng[e].nxt = i_reg_wdata[DATA_W-1:PTR_LSB];
      if (wr_sw[e])
        d.eng[e].sw = i_reg_wdata[DATA_W-1:PTR_LSB];
      // flag sets come after clears so a same-cycle event wins
      case (q.eng[e].st)
        ENG_IDLE:
        begin
          if (q.eng[e].en)
          begin
            if (q.eng[e].nxt == q.eng[e].sw)
              d.eng[e].st = ENG_WAIT;
            else
            begin
              d.eng[e].st  = ENG_FETCH;
              d.eng[e].req = 1'b1;
            end
          end
        end
        ENG_FETCH:
        begin
          if (wr_ctl[e] && !i_reg_wdata[BIT_EN])
          begin
            d.eng[e].abrt = 1'b1;
            d.eng[e].st   = ENG_IDLE;
          end
          else if (ev_ferr[e])
          begin
            d.eng[e].ferr = 1'b1;
            d.eng[e].iact = 1'b1;
            d.eng[e].en   = 1'b0;
            d.eng[e].st   = ENG_IDLE;
          end
          else if (ev_mis[e])
          begin
            d.eng[e].align = 1'b1;
            d.eng[e].iact  = 1'b1;
            d.eng[e].en    = 1'b0;
            d.eng[e].st    = ENG_IDLE;
          end
          else if (ev_done[e])
          begin
            d.eng[e].nxt = i_desc_next[e][DATA_W-1:PTR_LSB];
            if (i_desc_ioc[e])
            begin
              d.eng[e].done = 1'b1;
              d.eng[e].iact = 1'b1;
            end
            if (i_desc_next[e][DATA_W-1:PTR_LSB] == q.eng[e].sw)
              d.eng[e].st = ENG_WAIT;
            else
              d.eng[e].req = 1'b1;
          end
        end
        ENG_WAIT:
        begin
          if (!q.eng[e].en)
            d.eng[e].st = ENG_IDLE;
          else if (q.eng[e].nxt != q.eng[e].sw)
          begin
            d.eng[e].st  = ENG_FETCH;
            d.eng[e].req = 1'b1;
          end
        end
        default:
        begin
          d.eng[e].st = ENG_IDLE;
        end
      endcase
      // engine held in reset, only the reset bit survives
      if (q.eng[e].rst)
      begin
        rst_keep     = d.eng[e].rst;
        d.eng[e]     = '0;
        d.eng[e].nxt = PTR_RST;
        d.eng[e].sw  = PTR_RST;
        d.eng[e].rst = rst_keep;
      end
    end
    if (i_reg_wr && (i_reg_addr == COMMON_BASE))
      d.gie = i_reg_wdata[BIT_GIE];
    d.irq    = q.gie && (|eng_irq);
    d.rvalid = i_reg_rd;
    d.rdata  = '0;
    if (i_reg_rd && sel[2])
    begin
      if (off == REG_ENG_CTL)
        d.rdata = ctl_word(q.eng[sel[1:0]]);
      else if (off == REG_NEXT_PTR)
        d.rdata = {q.eng[sel[1:0]].nxt, 5'h00};
      else if (off == REG_SW_PTR)
        d.rdata = {q.eng[sel[1:0]].sw, 5'h00};
      else if (off == REG_BYTE_CNT)
        d.rdata = {byte_cnt[sel[1:0]], smp_cnt[sel[1:0]]};
    end
    else if (i_reg_rd && (i_reg_addr == COMMON_BASE))
    begin
      d.rdata[BIT_GIE]   = q.gie;
      d.rdata[BIT_GACT]  = q.irq;
      d.rdata[BIT_GPEND] = |eng_irq;
      d.rdata[S2C_LSB+7:S2C_LSB] = 8'(eng_irq[NUM_S2C-1:0]);
      d.rdata[C2S_LSB+7:C2S_LSB] = 8'(eng_irq[NUM_ENG-1:NUM_S2C]);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata  = q.rdata;
  assign o_reg_rvalid = q.rvalid;
  assign o_irq        = q.irq;
  for (genvar g = 0; g < NUM_ENG; g++)
  begin : g_out
    assign o_fetch_req[g]    = q.eng[g].req;
    assign o_fetch_ptr[g]    = q.eng[g].nxt;
    assign o_user_rst_req[g] = q.eng[g].rreq;
    assign o_user_rst[g]     = q.eng[g].rst;
  end

  // ----------------------------------------------------------------
  // checks on engine 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_misaligned;
    (q.eng[0].st == ENG_FETCH) && i_desc_done[0] && !i_fetch_err[0]
      && (i_desc_next[0][4:0] != 5'h00) && !wr_ctl[0] && !q.eng[0].rst;
  endsequence

  sequence s_halted;
    (q.eng[0].st == ENG_IDLE) && !q.eng[0].en;
  endsequence

  property p_align_abort;
    s_misaligned |=> (q.eng[0].align && q.eng[0].iact) ##0 s_halted;
  endproperty
  a_align_abort: assert property (p_align_abort)
    else $error("misaligned descriptor did not abort");

  property p_fetch_err;
    ((q.eng[0].st == ENG_FETCH) && i_fetch_err[0] && !wr_ctl[0] && !q.eng[0].rst)
      |=> (q.eng[0].ferr && q.eng[0].iact) ##0 s_halted;
  endproperty
  a_fetch_err: assert property (p_fetch_err)
    else $error("fetch error not flagged");

  property p_done_flag;
    ((q.eng[0].st == ENG_FETCH) && i_desc_done[0] && i_desc_ioc[0] && !i_fetch_err[0]
      && (i_desc_next[0][4:0] == 5'h00) && !wr_ctl[0] && !q.eng[0].rst)
      |=> (q.eng[0].done && q.eng[0].iact);
  endproperty
  a_done_flag: assert property (p_done_flag)
    else $error("descriptor completion flag not set");

  property p_sw_abort;
    ((q.eng[0].st == ENG_FETCH) && wr_ctl[0] && !i_reg_wdata[BIT_EN] && !q.eng[0].rst)
      |=> q.eng[0].abrt && (q.eng[0].st == ENG_IDLE);
  endproperty
  a_sw_abort: assert property (p_sw_abort)
    else $error("software abort not recorded");

  property p_wait_equal;
    ((q.eng[0].st == ENG_IDLE) && q.eng[0].en && (q.eng[0].nxt == q.eng[0].sw)
      && !wr_sw[0] && !q.eng[0].rst) |=> (q.eng[0].st == ENG_WAIT) ##1 !q.eng[0].req;
  endproperty
  a_wait_equal: assert property (p_wait_equal)
    else $error("engine did not wait on equal pointers");

  property p_ptr_lock;
    (q.eng[0].en && (q.eng[0].st == ENG_WAIT) && !q.eng[0].rst) |=> $stable(q.eng[0].nxt);
  endproperty
  a_ptr_lock: assert property (p_ptr_lock)
    else $error("next pointer changed while enabled");

  property p_gated_irq;
    (q.gie && q.eng[0].ien && q.eng[0].iact) |=> o_irq;
  endproperty
  a_gated_irq: assert property (p_gated_irq)
    else $error("gated interrupt not raised");

  property p_rst_ack;
    (q.eng[0].rreq && i_user_rst_ack[0] && !wr_ctl[0] && !q.eng[0].rst)
      |=> !o_user_rst_req[0];
  endproperty
  a_rst_ack: assert property (p_rst_ack)
    else $error("reset request not cleared by acknowledge");

  property p_eng_reset;
    (q.eng[0].rst && !wr_ctl[0]) ##1 !wr_ctl[0]
      |-> (o_user_rst[0] && (q.eng[0].st == ENG_IDLE) && !q.eng[0].iact) [*2];
  endproperty
  a_eng_reset: assert property (p_eng_reset)
    else $error("engine reset not applied");
endmodule : sgdc_top

// [bench/sgdc_partner.sv]
// datapath and user logic model facing the dma control block
module sgdc_partner
  import sgdc_pkg::*;
(
  input  wire logic                                        i_ref_clk,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_fetch_req,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0]                i_user_rst_req,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0][1:0]           i_mode,
  input  wire logic [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::DATA_W-1:0] i_next,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_desc_done,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_desc_ioc,
  output logic      [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::DATA_W-1:0] o_desc_next,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_fetch_err,
  output logic      [sgdc_pkg::NUM_ENG-1:0][sgdc_pkg::XFER_W-1:0] o_xfer_bytes,
  output logic      [sgdc_pkg::NUM_ENG-1:0]                o_user_rst_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 0 good, 1 fetch error, 2 never answers (for abort)
  int wt [NUM_ENG];
  initial
  begin
    o_desc_done    = '0;
    o_fetch_err    = '0;
    o_user_rst_ack = '0;
    foreach (wt[i]) wt[i] = 0;
  end
  assign o_desc_ioc   = o_desc_done;
  assign o_xfer_bytes = {NUM_ENG{16'h0008}};
  // next field not held outside a done pulse
  for (genvar g = 0; g < NUM_ENG; g++)
  begin : g_nx
    assign o_desc_next[g] = o_desc_done[g] ? i_next[g] : ~i_next[g];
  end
  always @(negedge i_ref_clk)
  begin
    for (int i = 0; i < NUM_ENG; i++)
    begin
      o_desc_done[i] = 1'b0;
      o_fetch_err[i] = 1'b0;
      if (i_fetch_req[i])
        wt[i] = 3;
      else if (wt[i] > 0)
      begin
        wt[i]--;
        if (wt[i] == 0 && i_mode[i] == 2'h0) o_desc_done[i] = 1'b1;
        if (wt[i] == 0 && i_mode[i] == 2'h1) o_fetch_err[i] = 1'b1;
      end
      o_user_rst_ack[i] = i_user_rst_req[i];
    end
  end
endmodule : sgdc_partner

// [bench/testbench.sv]
// self-checking bench of the dma control block
module testbench
  import sgdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 20;
  localparam logic [15:0] EB [4] = '{CH_S2C0_BASE, CH_S2C1_BASE, CH_C2S0_BASE, CH_C2S1_BASE};
  logic                                clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [15:0]                         addr = '0;
  logic [31:0]                         wdata = '0, rdata, v;
  logic                                rvalid, irq;
  logic [NUM_ENG-1:0]                  freq, done, ioc, ferr, rreq, rack, urst;
  logic [NUM_ENG-1:0][PTR_W-1:0]       fptr;
  logic [NUM_ENG-1:0][DATA_W-1:0]      dnext, pnext = '0;
  logic [NUM_ENG-1:0][XFER_W-1:0]      xb;
  logic [NUM_ENG-1:0][1:0]             mode = '0;
  int                                  fails = 0, tests_run = 0, cyc = 0;

  always #5 clk = ~clk;
  sgdc_top #(.TICK_CYCLES(TICK)) u_sgdc_top (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_fetch_req(freq), .o_fetch_ptr(fptr), .i_desc_done(done),
    .i_desc_ioc(ioc), .i_desc_next(dnext), .i_fetch_err(ferr), .i_xfer_bytes(xb),
    .o_user_rst_req(rreq), .i_user_rst_ack(rack), .o_user_rst(urst), .o_irq(irq));
  sgdc_partner u_sgdc_partner (.i_ref_clk(clk), .i_fetch_req(freq), .i_user_rst_req(rreq),
    .i_mode(mode), .i_next(pnext), .o_desc_done(done), .o_desc_ioc(ioc), .o_desc_next(dnext),
    .o_fetch_err(ferr), .o_xfer_bytes(xb), .o_user_rst_ack(rack));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] ra(int i, logic [7:0] r);
    return EB[i] | {8'h00, r};
  endfunction : ra
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask : cycles
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    @(negedge clk);
    rd = 1'b1; addr = a;
    @(negedge clk);
    rd = 1'b0; v = rdata;
    chk("rvalid", 32'h1, {31'h0, rvalid});
    chk($sformatf("reg %h", a), e, v);
  endtask : rchk
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
    begin
      rchk(ra(i, REG_ENG_CTL), 32'h0);
      rchk(ra(i, REG_NEXT_PTR), 32'h0);
    end
    rchk(COMMON_BASE, 32'h0);
  endtask : t_reset
  task automatic t_bytes;
    // read lands mid-interval, after the third sample
    cycles(3 * TICK - 10);
    rchk(ra(0, REG_BYTE_CNT), {30'(8 * TICK / 4), 2'h3});
    cycles(TICK - 2);
    rchk(ra(0, REG_BYTE_CNT), {30'(8 * TICK / 4), 2'h0});
  endtask : t_bytes
  task automatic t_map;
    for (int i = 0; i < 4; i++) wr_reg(ra(i, REG_SW_PTR), 32'h1000 * (i + 1) + 32'h1F);
    for (int i = 0; i < 4; i++) rchk(ra(i, REG_SW_PTR), 32'h1000 * (i + 1));
    rchk(16'h4010, 32'h0);
  endtask : t_map
  task automatic t_start(input int i, input logic [31:0] c);
    wr_reg(ra(i, REG_NEXT_PTR), 32'h40);
    wr_reg(ra(i, REG_SW_PTR), 32'h80);
    wr_reg(ra(i, REG_ENG_CTL), c);
    cycles(12);
  endtask : t_start
  task automatic t_run;
    pnext[0] = 32'h80;
    wr_reg(COMMON_BASE, 32'h1);
    t_start(0, 32'h101);
    rchk(ra(0, REG_ENG_CTL), 32'h907);
    chk("fetch_ptr", 32'h4, {5'h0, fptr[0]});
    chk("irq", 32'h1, {31'h0, irq});
    wr_reg(ra(0, REG_NEXT_PTR), 32'h1E0);
    rchk(ra(0, REG_NEXT_PTR), 32'h80);
    wr_reg(ra(0, REG_ENG_CTL), 32'h107);
    rchk(ra(0, REG_ENG_CTL), 32'h901);
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(ra(0, REG_ENG_CTL), 32'h0);
    wr_reg(ra(0, REG_ENG_CTL), 32'h100);
    rchk(ra(0, REG_ENG_CTL), 32'h900);
  endtask : t_run
  task automatic t_errs;
    mode[2] = 2'h1;
    t_start(2, 32'h101);
    rchk(ra(2, REG_ENG_CTL), 32'h13);
    pnext[1] = 32'h44;
    t_start(1, 32'h101);
    rchk(ra(1, REG_ENG_CTL), 32'h0B);
    mode[3] = 2'h2;
    t_start(3, 32'h100);
    rchk(ra(3, REG_ENG_CTL), 32'h500);
    wr_reg(ra(3, REG_ENG_CTL), 32'h0);
    rchk(ra(3, REG_ENG_CTL), 32'h20);
    rchk(COMMON_BASE, 32'h01020007);
    wr_reg(COMMON_BASE, 32'h0);
    cycles(2);
    chk("irq", 32'h0, {31'h0, irq});
    rchk(COMMON_BASE, 32'h01020004);
  endtask : t_errs
  task automatic t_rst;
    wr_reg(ra(0, REG_ENG_CTL), 32'h4000);
    for (int k = 0; k < 8 && rreq[0] !== 1'b1; k++) @(negedge clk);
    chk("user_rst_req", 32'h1, {31'h0, rreq[0]});
    for (int k = 0; k < 8 && rreq[0] !== 1'b0; k++) @(negedge clk);
    rchk(ra(0, REG_ENG_CTL), 32'h0);
    wr_reg(ra(0, REG_ENG_CTL), 32'h8000);
    cycles(2);
    chk("user_rst", 32'h1, {28'h0, urst});
    rchk(ra(0, REG_NEXT_PTR), 32'h0);
    wr_reg(ra(0, REG_ENG_CTL), 32'h0);
    cycles(2);
    chk("user_rst", 32'h0, {28'h0, urst});
  endtask : t_rst
  task automatic t_flags;
    mode[0] = 2'h1;
    t_start(0, 32'h100);
    rchk(ra(0, REG_ENG_CTL), 32'h12);
    mode[0] = 2'h0;
    pnext[0] = 32'h44;
    t_start(0, 32'h100);
    rchk(ra(0, REG_ENG_CTL), 32'h1A);
    mode[0] = 2'h2;
    t_start(0, 32'h100);
    wr_reg(ra(0, REG_ENG_CTL), 32'h0);
    rchk(ra(0, REG_ENG_CTL), 32'h3A);
  endtask : t_flags

  initial
  begin
    cycles(12);
    rst_b = 1'b1;
    t_reset();
    t_bytes();
    t_map();
    t_run();
    t_errs();
    t_rst();
    t_flags();
    tally_and_finish();
  end
endmodule : testbench
